// file: sim/ast_rx_model.sv
// Behavioural far-end serial receiver that frames characters off the transmit pin.
module ast_rx_model (
	input wire logic clk_sys,
	input wire logic line,
	input wire logic oe,
	input wire logic inv,
	input wire logic nine,
	input wire logic [15:0] period
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pad;
	// A released pin floats up to its pull-up level.
	assign pad = oe ? line : 1'b1;
	logic [9:0] rx_q[$];
	longint start_q[$];
	longint cyc_n = 0;
	always @(posedge clk_sys) cyc_n <= cyc_n + 1;
	// Bits are sampled mid-period, so a wrong bit length shows up as a shifted character once its error adds up to half a period.
	initial begin : rx_loop
		logic [9:0] f;
		forever begin
			@(posedge clk_sys);
			if (oe && (pad ^ inv) == 1'b0) begin
				start_q.push_back(cyc_n);
				f = '0;
				repeat (period / 2) @(posedge clk_sys);
				for (int i = 0; i < (nine ? 9 : 8); i++) begin
					repeat (period) @(posedge clk_sys);
					f[i] = pad ^ inv;
				end
				repeat (period) @(posedge clk_sys);
				f[9] = pad ^ inv;
				rx_q.push_back(f);
			end
		end
	end
endmodule : ast_rx_model

// file: sim/ast_tx_bench.sv
// Self-checking bench for the asynchronous serial transmitter.
module ast_tx_bench
	import ast_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] SP = 32'h1 << AST_CTRL_SERIAL_PORT_ENABLE;
	localparam logic [31:0] EN = SP | (32'h1 << AST_CTRL_TRANSMIT_ENABLE) | (32'h1 << AST_CTRL_HS);
	localparam logic [31:0] NI = (32'h1 << AST_CTRL_NINE) | (32'h1 << AST_CTRL_D9);
	localparam logic [31:0] IV = 32'h1 << AST_CTRL_INV;
	logic clk_sys = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] dat = 32'h0, rdat, dat_o;
	logic ack, pin, oe, irq, inv = 1'b0, nine = 1'b0;
	logic [15:0] period = 16'h8;
	int error_cnt = 0, cmp_count = 0;
	ast_tx ast_tx_inst (.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .transmit_clock_pin_out(pin),
		.transmit_clock_pin_oe(oe), .tx_irq(irq));
	ast_rx_model ast_rx_model_inst (.clk_sys(clk_sys), .line(pin), .oe(oe), .inv(inv),
		.nine(nine), .period(period));
	initial forever #25 clk_sys = ~clk_sys;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Called just after a rising edge; holds the request until ack is sampled high.
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		@(posedge clk_sys);
		while (ack !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk_sys);
		end
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_sys);
		chk("wb_ack_o", 32'h1, {31'h0, n < 20});
	endtask : bus
	task automatic wait_rx(input int n);
		int k;
		k = 0;
		while (ast_rx_model_inst.rx_q.size() < n && k < 20000) begin
			k++;
			@(posedge clk_sys);
		end
		chk("frames", n, ast_rx_model_inst.rx_q.size());
	endtask : wait_rx
	task automatic rx_chk(input logic [9:0] e);
		chk("frame", {22'h0, e}, {22'h0, ast_rx_model_inst.rx_q.pop_front()});
	endtask : rx_chk
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	task automatic t_reset;
		chk("pin", 32'h1, {31'h0, pin});
		chk("oe", 32'h0, {31'h0, oe});
		bus(1'b0, AST_CTRL_OFS, 32'h0);
		chk("ctrl", {23'h0, AST_CTRL_RST}, rdat);
		bus(1'b1, AST_STAT_OFS, 32'h7);
		bus(1'b0, AST_STAT_OFS, 32'h0);
		chk("status", 32'h2, rdat);
		bus(1'b0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, rdat);
		bus(1'b1, AST_CTRL_OFS, EN | (32'h1 << AST_CTRL_SYNC));
		bus(1'b1, AST_DATA_OFS, 32'h55);
		chk("oe", 32'h0, {31'h0, oe});
		bus(1'b0, AST_STAT_OFS, 32'h0);
		chk("status", 32'h2, rdat);
	endtask : t_reset
	task automatic t_b2b;
		bus(1'b1, AST_BAUD_OFS, 32'h1);
		bus(1'b1, AST_CTRL_OFS, EN);
		chk("oe", 32'h1, {31'h0, oe});
		bus(1'b0, AST_STAT_OFS, 32'h0);
		chk("status", 32'h3, rdat);
		chk("irq", 32'h0, {31'h0, irq});
		bus(1'b1, AST_CTRL_OFS, EN | (32'h1 << AST_CTRL_IE));
		chk("irq", 32'h1, {31'h0, irq});
		bus(1'b1, AST_DATA_OFS, 32'ha5);
		bus(1'b1, AST_DATA_OFS, 32'h3c);
		bus(1'b0, AST_STAT_OFS, 32'h0);
		chk("status", 32'h0, rdat);
		chk("irq", 32'h0, {31'h0, irq});
		wait_rx(2);
		rx_chk(10'h2a5);
		rx_chk(10'h23c);
		chk("gap", 32'd80, 32'(ast_rx_model_inst.start_q[1] - ast_rx_model_inst.start_q[0]));
		repeat (8) @(posedge clk_sys);
		bus(1'b0, AST_STAT_OFS, 32'h0);
		chk("status", 32'h7, rdat);
		ast_rx_model_inst.start_q.delete();
	endtask : t_b2b
	task automatic t_nine;
		bus(1'b1, AST_CTRL_OFS, SP | NI | IV);
		inv <= 1'b1;
		nine <= 1'b1;
		bus(1'b1, AST_CTRL_OFS, EN | NI | IV);
		chk("pin", 32'h0, {31'h0, pin});
		bus(1'b1, AST_DATA_OFS, 32'h5a);
		wait_rx(1);
		rx_chk(10'h35a);
		repeat (8) @(posedge clk_sys);
		bus(1'b1, AST_CTRL_OFS, SP);
		inv <= 1'b0;
		nine <= 1'b0;
		ast_rx_model_inst.start_q.delete();
	endtask : t_nine
	task automatic t_wide;
		period <= 16'd1028;
		bus(1'b1, AST_BAUD_OFS, 32'h100);
		bus(1'b1, AST_CTRL_OFS, EN | (32'h1 << AST_CTRL_WIDE));
		bus(1'b1, AST_DATA_OFS, 32'h81);
		wait_rx(1);
		rx_chk(10'h281);
		repeat (1028) @(posedge clk_sys);
		period <= 16'h8;
		bus(1'b1, AST_BAUD_OFS, 32'h1);
	endtask : t_wide
	task automatic t_abort;
		bus(1'b1, AST_DATA_OFS, 32'h00);
		repeat (20) @(posedge clk_sys);
		bus(1'b1, AST_CTRL_OFS, SP);
		chk("pin", 32'h1, {31'h0, pin});
		chk("oe", 32'h0, {31'h0, oe});
		bus(1'b0, AST_STAT_OFS, 32'h0);
		chk("status", 32'h2, rdat);
		repeat (100) @(posedge clk_sys);
		ast_rx_model_inst.rx_q.delete();
		bus(1'b1, AST_CTRL_OFS, EN);
		bus(1'b1, AST_DATA_OFS, 32'hc3);
		wait_rx(1);
		rx_chk(10'h2c3);
	endtask : t_abort
	initial begin
		#3000000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_b2b();
		t_nine();
		t_wide();
		t_abort();
		report_and_stop();
	end
endmodule : ast_tx_bench

// file: verilog/ast_baud.sv
// Baud tick generator dividing the system clock by prescale times divisor plus one.
module ast_baud
	import ast_pkg::*;
#(
	parameter int DIV_W = AST_DIV_W
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic run,
	input wire logic restart,
	input wire logic high_speed,
	input wire logic wide,
	input wire logic [DIV_W-1:0] divisor,
	output logic tick
);

	// The narrow-counter masking below assumes a sixteen-bit divisor.
	if (DIV_W != AST_DIV_W) begin : g_bad_div_w
		$error("ast_baud: divisor width must be 16");
	end

	logic [4:0] pre_q;
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] lim;
	logic [4:0] pre_lim;
	logic pre_end;

	// The narrow counter ignores the high divisor byte.
	assign lim = wide ? divisor : {8'h00, divisor[7:0]};
	assign pre_lim = high_speed ? 5'(AST_PRESC_HI - 1) : 5'(AST_PRESC_LO - 1);
	assign pre_end = (pre_q == pre_lim);
	assign tick = run && !restart && pre_end && (div_q == lim);

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			pre_q <= 5'h00;
			div_q <= '0;
		end else if (clk_en) begin
			if (!run || restart || tick) begin
				pre_q <= 5'h00;
				div_q <= '0;
			end else if (pre_end) begin
				pre_q <= 5'h00;
				div_q <= div_q + 1'b1;
			end else begin
				pre_q <= pre_q + 5'h01;
			end
		end
	end

	logic [23:0] gap_q;
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			gap_q <= 24'h000000;
		end else if (clk_en) begin
			gap_q <= (!run || restart || tick) ? 24'h000000 : gap_q + 24'h000001;
		end
	end

	a_tick_period: assert property (@(posedge clk_sys iff clk_en) disable iff (!resetn)
		tick |-> gap_q == 24'(({8'h00, lim} + 24'h1) * {19'h0, pre_lim + 5'h1} - 24'h1))
		else $error("baud tick period wrong");

endmodule : ast_baud

// file: verilog/ast_pkg.sv
// Constants, register map and types for the asynchronous serial transmitter.
// Notes on behaviour
// - Frame is start bit at space, 8 or 9 data bits, stop bit at mark.
// - Line rests at mark when idle; data bits held flat, no return to neutral.
// - Least significant data bit goes onto the line first.
// - Every bit, start and stop included, lasts exactly one baud period.
// - Bit timing comes from a divider of the system clock, 8-bit or 16-bit.
// - No parity is computed; software supplies any parity as ninth bit.
// - Transmission active only with transmit enable, port enable, clocked mode off.
// - Pin driven only while transmission active; port enable alone leaves it released.
// - A disabled section releases its pin for general purpose use.
// - Writing the holding buffer starts a character; empty shifter takes it at once.
// - Busy shifter: character waits for stop bit end, then transfers within one cycle.
// - Polarity bit 0 gives high-true line, 1 inverts idle and data.
// - Buffer-empty flag high when enabled and buffer empty; read-only.
// - Flag valid by the second instruction cycle after a buffer write.
// - Flag follows buffer regardless; request only when flag and its enable.
// - Shifter-empty status clears on load, sets after last bit; no interrupt.
// - Nine-bit mode shifts nine bits, ninth bit is the most significant.
// - Ninth bit written first; all nine bits captured at the buffer write.
package ast_pkg;

	localparam logic [3:0] AST_CTRL_OFS = 4'h0;
	localparam logic [3:0] AST_STAT_OFS = 4'h4;
	localparam logic [3:0] AST_DATA_OFS = 4'h8;
	localparam logic [3:0] AST_BAUD_OFS = 4'hc;

	localparam int AST_CTRL_SERIAL_PORT_ENABLE = 0;
	localparam int AST_CTRL_TRANSMIT_ENABLE = 1;
	localparam int AST_CTRL_SYNC = 2;
	localparam int AST_CTRL_NINE = 3;
	localparam int AST_CTRL_D9 = 4;
	localparam int AST_CTRL_INV = 5;
	localparam int AST_CTRL_HS = 6;
	localparam int AST_CTRL_WIDE = 7;
	localparam int AST_CTRL_IE = 8;
	localparam int AST_CTRL_W = 9;

	localparam int AST_STAT_FLAG = 0;
	localparam int AST_STAT_EMPTY = 1;
	localparam int AST_STAT_IRQ = 2;

	localparam logic [8:0] AST_CTRL_RST = 9'h000;
	localparam logic [15:0] AST_BAUD_RST = 16'h0000;

	// Clocks per divisor step for the low-speed and high-speed settings.
	localparam int AST_PRESC_LO = 16;
	localparam int AST_PRESC_HI = 4;
	localparam int AST_DIV_W = 16;

	localparam int AST_BITS_LO = 8;
	localparam int AST_BITS_HI = 9;

	localparam int AST_CLK_HZ = 20000000;

	typedef enum logic [1:0] {
		AST_IDLE = 2'b00,
		AST_START = 2'b01,
		AST_DATA = 2'b10,
		AST_STOP = 2'b11
	} ast_state_t;

endpackage : ast_pkg

// file: verilog/ast_tx.sv
// Asynchronous serial transmitter with a classic Wishbone register slave.
module ast_tx
	import ast_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic transmit_clock_pin_out,
	output logic transmit_clock_pin_oe,
	output logic tx_irq
);

	function automatic logic hit(input logic [3:0] adr, input logic [3:0] ofs);
		hit = (adr == ofs);
	endfunction : hit

	logic ack_q;
	logic req;
	logic wr;
	logic [AST_CTRL_W-1:0] ctrl_q;
	logic [15:0] baud_q;
	logic [8:0] hold_q;
	logic hold_full_q;
	logic [8:0] shift_q;
	logic [3:0] cnt_q;
	logic line_q;
	logic irq_q;
	logic [31:0] rdat_q;
	ast_state_t state_q;
	logic tick;
	logic active;
	logic flag;
	logic empty;
	logic load;
	logic load_idle;
	logic data_wr;
	logic [3:0] last_bit;

	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr = req && wb_we_i;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	assign active = ctrl_q[AST_CTRL_TRANSMIT_ENABLE] && ctrl_q[AST_CTRL_SERIAL_PORT_ENABLE] && !ctrl_q[AST_CTRL_SYNC];
	assign flag = active && !hold_full_q;
	assign empty = (state_q == AST_IDLE);
	assign data_wr = wr && hit(wb_adr_i, AST_DATA_OFS) && wb_sel_i[0];
	assign last_bit = ctrl_q[AST_CTRL_NINE] ? 4'(AST_BITS_HI - 1) : 4'(AST_BITS_LO - 1);

	// A waiting character moves in on the stop bit's closing tick, so the
	// next start bit follows with no idle gap at all.
	assign load_idle = active && hold_full_q && (state_q == AST_IDLE);
	assign load = load_idle || (active && hold_full_q && (state_q == AST_STOP) && tick);

	// Registers answer one cycle after the request; ack then drops for a cycle.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ack_q <= 1'b0;
		end else if (clk_en) begin
			ack_q <= req;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ctrl_q <= AST_CTRL_RST;
		end else if (clk_en && wr && hit(wb_adr_i, AST_CTRL_OFS)) begin
			if (wb_sel_i[0]) begin
				ctrl_q[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				ctrl_q[AST_CTRL_IE] <= wb_dat_i[AST_CTRL_IE];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			baud_q <= AST_BAUD_RST;
		end else if (clk_en && wr && hit(wb_adr_i, AST_BAUD_OFS)) begin
			if (wb_sel_i[0]) begin
				baud_q[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				baud_q[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rdat_q <= 32'h00000000;
		end else if (clk_en && req) begin
			rdat_q <= 32'h00000000;
			if (!wb_we_i && hit(wb_adr_i, AST_CTRL_OFS)) begin
				rdat_q[AST_CTRL_W-1:0] <= ctrl_q;
			end
			if (!wb_we_i && hit(wb_adr_i, AST_STAT_OFS)) begin
				rdat_q[AST_STAT_FLAG] <= flag;
				rdat_q[AST_STAT_EMPTY] <= empty;
				rdat_q[AST_STAT_IRQ] <= irq_q;
			end
		end
	end

	// The ninth bit is caught with the data write, so a later change of it
	// cannot alter a character already queued.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			hold_q <= 9'h000;
			hold_full_q <= 1'b0;
		end else if (clk_en) begin
			if (!active) begin
				hold_full_q <= 1'b0;
			end else if (data_wr) begin
				hold_q <= {ctrl_q[AST_CTRL_D9], wb_dat_i[7:0]};
				hold_full_q <= 1'b1;
			end else if (load) begin
				hold_full_q <= 1'b0;
			end
		end
	end

	ast_baud #(
		.DIV_W(AST_DIV_W)
	) u_baud (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.clk_en(clk_en),
		.run(active),
		.restart(load_idle),
		.high_speed(ctrl_q[AST_CTRL_HS]),
		.wide(ctrl_q[AST_CTRL_WIDE]),
		.divisor(baud_q),
		.tick(tick)
	);

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_q <= AST_IDLE;
			shift_q <= 9'h000;
			cnt_q <= 4'h0;
			line_q <= 1'b1;
		end else if (clk_en) begin
			if (!active) begin
				state_q <= AST_IDLE;
				line_q <= 1'b1;
			end else if (load) begin
				shift_q <= hold_q;
				cnt_q <= 4'h0;
				line_q <= 1'b0;
				state_q <= AST_START;
			end else if (tick) begin
				case (state_q)
					AST_START: begin
						line_q <= shift_q[0];
						shift_q <= {1'b0, shift_q[8:1]};
						state_q <= AST_DATA;
					end
					AST_DATA: begin
						if (cnt_q == last_bit) begin
							line_q <= 1'b1;
							state_q <= AST_STOP;
						end else begin
							line_q <= shift_q[0];
							shift_q <= {1'b0, shift_q[8:1]};
							cnt_q <= cnt_q + 4'h1;
						end
					end
					AST_STOP: begin
						state_q <= AST_IDLE;
					end
					default: begin
						state_q <= AST_IDLE;
						line_q <= 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			irq_q <= 1'b0;
		end else if (clk_en) begin
			irq_q <= flag && ctrl_q[AST_CTRL_IE];
		end
	end

	assign tx_irq = irq_q;
	assign transmit_clock_pin_out = line_q ^ ctrl_q[AST_CTRL_INV];
	// The pin is released whenever transmission is off, so it can serve other uses.
	assign transmit_clock_pin_oe = active;

	default clocking cb @(posedge clk_sys iff clk_en);
	endclocking
	default disable iff (!resetn);

	a_idle_mark: assert property (empty |-> line_q)
		else $error("line not at mark while idle");

	a_start_space: assert property (load |=> !line_q && state_q == AST_START)
		else $error("start bit not at space after load");

	a_stop_mark: assert property (state_q == AST_STOP |-> line_q)
		else $error("stop bit not at mark");

	a_lsb_first: assert property (
		(state_q == AST_START && tick && active && !load) |=> line_q == $past(shift_q[0]))
		else $error("first data bit is not the lsb");

	a_bit_count: assert property (
		state_q == AST_DATA |-> cnt_q <= last_bit)
		else $error("data bit counter past last bit");

	a_empty_clear: assert property (load |=> !empty)
		else $error("shifter empty not cleared on load");

	a_flag_enable: assert property ($rose(active) && !hold_full_q |-> flag)
		else $error("flag not set with transmit enable");

	a_flag_valid: assert property (data_wr && active |-> ##[1:2] !flag || load)
		else $error("flag not valid after buffer write");

	a_irq_gate: assert property (irq_q |-> $past(flag) && $past(ctrl_q[AST_CTRL_IE]))
		else $error("interrupt without flag and enable");

	a_back_to_back: assert property (
		(state_q == AST_STOP && tick && active && hold_full_q) |=> state_q == AST_START)
		else $error("queued character not moved after stop bit");

	a_abort_idle: assert property (!active |=> empty && line_q && !hold_full_q)
		else $error("disable did not abort the character");

	a_pin_release: assert property (!ctrl_q[AST_CTRL_SERIAL_PORT_ENABLE] |-> !transmit_clock_pin_oe)
		else $error("pin driven while port disabled");

	a_bus_ack: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle after request");

	c_eight_bit: cover property (
		state_q == AST_STOP && tick && !ctrl_q[AST_CTRL_NINE]);
	c_nine_bit: cover property (
		state_q == AST_STOP && tick && ctrl_q[AST_CTRL_NINE]);
	c_back_to_back: cover property (state_q == AST_STOP && load);
	c_abort: cover property (state_q == AST_DATA ##1 !active);
	c_inverted: cover property (state_q == AST_DATA && ctrl_q[AST_CTRL_INV]);

endmodule : ast_tx
